// >>> shared/wport_pkg.sv
// Shared constants and types for the burst write port
package wport_pkg;
    // Lane geometry
    localparam int NIBBLE_WIDTH = 4;
    localparam int NIBBLE_LANES = 2;
    localparam int BYTE_WIDTH = 9;
    localparam int BYTE_LANES_MAX = 4;
    localparam int DATA_WIDTH_X8 = 8;
    localparam int DATA_WIDTH_X36 = 36;
    // Default configuration: 36-bit words, 19 address bits
    localparam int DATA_WIDTH_DEF = 36;
    localparam int ADDR_WIDTH_DEF = 19;
    localparam int FIFO_DEPTH_DEF = 16;
    // Words in one write burst
    localparam int BURST_WORDS = 2;
    // Reset values
    localparam logic SELECT_IDLE = 1'b1;

    typedef enum {
        PHASE_IDLE,
        PHASE_SECOND
    } phase_type;

    // Number of mask lanes for a data width
    function automatic int lane_count(input int width);
        if (width == DATA_WIDTH_X8) begin
            return NIBBLE_LANES;
        end
        return (width + BYTE_WIDTH - 1) / BYTE_WIDTH;
    endfunction : lane_count

    // Width of one mask lane for a data width
    function automatic int lane_width(input int width);
        if (width == DATA_WIDTH_X8) begin
            return NIBBLE_WIDTH;
        end
        return BYTE_WIDTH;
    endfunction : lane_width
endpackage : wport_pkg

// >>> shared/wport_if.sv
// Pin-level write port between controller and memory
`timescale 1ns/1ps
interface wport_if
    import wport_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_WIDTH_DEF,
    parameter int ADDR_WIDTH = ADDR_WIDTH_DEF
) (
    input wire logic clk
);
    localparam int LANES = lane_count(DATA_WIDTH);
    logic write_port_select_n;
    logic [ADDR_WIDTH-1:0] address;
    logic [DATA_WIDTH-1:0] write_data;
    logic [LANES-1:0] lane_write_select_n;

    modport controller (
        input clk,
        output write_port_select_n,
        output address,
        output write_data,
        output lane_write_select_n
    );

    modport memory (
        input clk,
        input write_port_select_n,
        input address,
        input write_data,
        input lane_write_select_n
    );
endinterface : wport_if

// >>> rtl/wport_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module wport_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    // Count is one bit wider than the pointers so that full is distinct from empty
    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : wport_fifo

// >>> rtl/wport_controller.sv
// Controller end: turns queued burst requests into pin activity
`timescale 1ns/1ps
module wport_controller
    import wport_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_WIDTH_DEF,
    parameter int ADDR_WIDTH = ADDR_WIDTH_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    wport_if.controller PINS,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [ADDR_WIDTH-1:0] REQ_ADDRESS,
    input wire logic [DATA_WIDTH-1:0] REQ_DATA_FIRST,
    input wire logic [DATA_WIDTH-1:0] REQ_DATA_SECOND,
    input wire logic [lane_count(DATA_WIDTH)-1:0] REQ_ENABLE_FIRST,
    input wire logic [lane_count(DATA_WIDTH)-1:0] REQ_ENABLE_SECOND,
    output logic BUSY
);
    localparam int LANES = lane_count(DATA_WIDTH);
    localparam int ENTRY = ADDR_WIDTH + 2 * DATA_WIDTH + 2 * LANES;

    logic [ENTRY-1:0] head;
    logic head_valid;
    logic head_ready;
    phase_type phase;
    logic [DATA_WIDTH-1:0] second_data;
    logic [LANES-1:0] second_enable;

    wport_fifo #(.WIDTH(ENTRY), .DEPTH(FIFO_DEPTH)) queue (
        .clk(CLK),
        .rst(RST),
        .in_valid(REQ_VALID),
        .in_ready(REQ_READY),
        .in_data({REQ_ADDRESS, REQ_DATA_FIRST, REQ_DATA_SECOND,
                  REQ_ENABLE_FIRST, REQ_ENABLE_SECOND}),
        .out_valid(head_valid),
        .out_ready(head_ready),
        .out_data(head)
    );

    // A new burst may start only on the first half of a beat pair
    assign head_ready = (phase == PHASE_IDLE);
    assign BUSY = head_valid || (phase == PHASE_SECOND);

    always_ff @(posedge CLK) begin
        if (RST) begin
            phase <= PHASE_IDLE;
        end else begin
            unique case (phase)
                PHASE_IDLE: begin
                    if (head_valid) begin
                        phase <= PHASE_SECOND;
                    end
                end
                PHASE_SECOND: begin
                    phase <= PHASE_IDLE;
                end
            endcase
        end
    end

    // Pins: select, address and first word with its mask in one cycle,
    // then second word with its mask in the next
    always_ff @(posedge CLK) begin
        if (RST) begin
            PINS.write_port_select_n <= SELECT_IDLE;
            PINS.address <= '0;
            PINS.write_data <= '0;
            PINS.lane_write_select_n <= '1;
            second_data <= '0;
            second_enable <= '0;
        end else if (phase == PHASE_IDLE && head_valid) begin
            PINS.write_port_select_n <= 1'b0;
            PINS.address <= head[ENTRY-1 -: ADDR_WIDTH];
            PINS.write_data <= head[2*LANES+2*DATA_WIDTH-1 -: DATA_WIDTH];
            PINS.lane_write_select_n <= ~head[2*LANES-1 -: LANES];
            second_data <= head[2*LANES+DATA_WIDTH-1 -: DATA_WIDTH];
            second_enable <= head[LANES-1:0];
        end else if (phase == PHASE_SECOND) begin
            PINS.write_port_select_n <= SELECT_IDLE;
            PINS.write_data <= second_data;
            PINS.lane_write_select_n <= ~second_enable;
        end else begin
            PINS.write_port_select_n <= SELECT_IDLE;
            PINS.lane_write_select_n <= '1;
        end
    end
endmodule : wport_controller

// >>> rtl/wport_memory.sv
// Memory end: burst write capture with per-lane masking into an array
//
// Contract
// - Data sampled on both clock phases during writes
// - Low port select at first edge starts write
// - High port select ignores data; array unchanged
// - 8-bit mode: two nibble selects, low/high nibble
// - Unselected nibbles keep their old contents
// - Nibble selects align with their data word
// - Deasserted nibble select: nibble not written
// - Byte selects gate 9-bit lanes, 0 lowest
// - Unselected byte lanes keep their old contents
// - Byte selects align with their data word
// - Deasserted byte select: lane not written
// - Write address taken with the write
// - Address ignored while port deselected
//
// The two input clock rising edges are modelled as two successive CLK
// cycles: beat 0 on the cycle the select is low, beat 1 on the next.
`timescale 1ns/1ps
module wport_memory
    import wport_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_WIDTH_DEF,
    parameter int ADDR_WIDTH = ADDR_WIDTH_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    wport_if.memory PINS,
    input wire logic [ADDR_WIDTH-1:0] READ_ADDRESS,
    input wire logic READ_BEAT,
    output logic [DATA_WIDTH-1:0] READ_DATA,
    output logic WRITE_DONE
);
    localparam int LANES = lane_count(DATA_WIDTH);
    localparam int LW = lane_width(DATA_WIDTH);
    localparam int WORDS = (1 << ADDR_WIDTH) * BURST_WORDS;

    logic [DATA_WIDTH-1:0] array [WORDS];
    phase_type phase;
    logic [ADDR_WIDTH-1:0] write_address;
    wire logic [DATA_WIDTH-1:0] next_word;
    logic [DATA_WIDTH-1:0] old_word;
    logic write_beat;
    logic beat_index;
    logic [ADDR_WIDTH:0] word_index;

    // Port select is honoured only on the first-phase edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase <= PHASE_IDLE;
        end else begin
            unique case (phase)
                PHASE_IDLE: begin
                    if (!PINS.write_port_select_n) begin
                        phase <= PHASE_SECOND;
                    end
                end
                PHASE_SECOND: begin
                    phase <= PHASE_IDLE;
                end
            endcase
        end
    end

    // Address latched only for a selected write
    always_ff @(posedge CLK) begin
        if (RST) begin
            write_address <= '0;
        end else if (phase == PHASE_IDLE && !PINS.write_port_select_n) begin
            write_address <= PINS.address;
        end
    end

    // Deselected idle-phase cycles write nothing, so data and address are ignored
    assign write_beat = (phase == PHASE_SECOND) ||
                        (phase == PHASE_IDLE && !PINS.write_port_select_n);
    assign beat_index = (phase == PHASE_SECOND);
    assign word_index = (phase == PHASE_SECOND) ?
                        {write_address, beat_index} : {PINS.address, beat_index};
    assign old_word = array[word_index];

    // Per-lane merge; mask and data are from the same edge
    generate
        for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
            localparam int LO = lane * LW;
            localparam int HI = (LO + LW > DATA_WIDTH) ? DATA_WIDTH - 1 : LO + LW - 1;
            // Each lane drives its own slice of a net, so no slice has two writers
            assign next_word[HI:LO] = PINS.lane_write_select_n[lane] ?
                old_word[HI:LO] : PINS.write_data[HI:LO];
        end
    endgenerate
    // Nibble lanes in x8, 9-bit byte lanes otherwise

    always_ff @(posedge CLK) begin
        if (write_beat) begin
            array[word_index] <= next_word;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            READ_DATA <= '0;
            WRITE_DONE <= 1'b0;
        end else begin
            READ_DATA <= array[{READ_ADDRESS, READ_BEAT}];
            WRITE_DONE <= (phase == PHASE_SECOND);
        end
    end
endmodule : wport_memory

// >>> bench/wport_properties.sv
// Pin-level checks on the write port joining controller and memory
`timescale 1ns/1ps
module wport_properties
    import wport_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_WIDTH_DEF,
    parameter int ADDR_WIDTH = ADDR_WIDTH_DEF
) (
    input wire logic clk,
    input wire logic RST,
    input wire logic write_port_select_n,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic [DATA_WIDTH-1:0] write_data,
    input wire logic [lane_count(DATA_WIDTH)-1:0] lane_write_select_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (RST);
    sequence s_beat0;
        !write_port_select_n;
    endsequence
    sequence s_beat1;
        write_port_select_n;
    endsequence
    a_burst_two_beats: assert property (s_beat0 |=> s_beat1)
        else $error("select low on two edges in a row");
    a_idle_lanes_off: assert property (s_beat1 ##1 s_beat1 |-> &lane_write_select_n)
        else $error("lane select active outside a burst");
    a_lanes_in_burst: assert property (!(&lane_write_select_n)
        |-> !write_port_select_n || !$past(write_port_select_n))
        else $error("lane select not aligned with a burst word");
    a_first_after_reset: assert property ($fell(RST) |-> s_beat1)
        else $error("write started out of reset");
    // Reset checks must see the reset cycle itself, so they drop the default disable
    a_reset_deselect: assert property (disable iff (1'b0) RST |=> s_beat1)
        else $error("select low after reset");
    a_reset_lanes_off: assert property (disable iff (1'b0) RST |=> &lane_write_select_n)
        else $error("lane select low after reset");
    a_reset_data_zero: assert property (disable iff (1'b0) RST |=> write_data == '0)
        else $error("write data not cleared by reset");
    a_reset_addr_zero: assert property (disable iff (1'b0) RST |=> address == '0)
        else $error("address not cleared by reset");
endmodule : wport_properties

// >>> bench/testbench.sv
// Self-checking bench: controller and memory joined across the write port
`timescale 1ns/1ps
module testbench;
    import wport_pkg::*;
    localparam int AW = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [AW-1:0] req_address = '0;
    logic [35:0] req_d0 = '0;
    logic [35:0] req_d1 = '0;
    logic [3:0] req_e0 = '0;
    logic [3:0] req_e1 = '0;
    logic [AW-1:0] read_address = '0;
    logic read_beat = 1'b0;
    logic req_ready, busy, write_done;
    logic [35:0] read_data;
    int failures = 0;
    int tests_run = 0;
    int refused = 0;
    int dones = 0;
    wport_if #(.ADDR_WIDTH(AW)) u_wport_if (.clk(clk));
    wport_controller #(.ADDR_WIDTH(AW)) u_wport_controller (.CLK(clk), .RST(rst),
        .PINS(u_wport_if), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_ADDRESS(req_address), .REQ_DATA_FIRST(req_d0), .REQ_DATA_SECOND(req_d1),
        .REQ_ENABLE_FIRST(req_e0), .REQ_ENABLE_SECOND(req_e1), .BUSY(busy));
    wport_memory #(.ADDR_WIDTH(AW)) u_wport_memory (.CLK(clk), .RST(rst), .PINS(u_wport_if),
        .READ_ADDRESS(read_address), .READ_BEAT(read_beat), .READ_DATA(read_data),
        .WRITE_DONE(write_done));
    wport_properties #(.ADDR_WIDTH(AW)) u_wport_properties (.clk(clk), .RST(rst),
        .write_port_select_n(u_wport_if.write_port_select_n), .address(u_wport_if.address),
        .write_data(u_wport_if.write_data), .lane_write_select_n(u_wport_if.lane_write_select_n));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (write_done === 1'b1) dones++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] en);
        for (int b = 0; b < 36; b++) if (en[b / BYTE_WIDTH]) o[b] = n[b];
        return o;
    endfunction : merge
    // Leaves the request raised so back-to-back calls keep one driver per step
    task automatic send(input int a, input logic [35:0] d0, d1, input logic [3:0] e0, e1);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_address <= AW'(a);
        req_d0 <= d0;
        req_d1 <= d1;
        req_e0 <= e0;
        req_e1 <= e1;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 200) begin
            refused++;
            n++;
            @(negedge clk);
        end
        if (n >= 200) failures++;
        @(posedge clk);
    endtask : send
    task automatic drain;
        int n;
        n = 0;
        req_valid <= 1'b0;
        @(posedge clk);
        while (busy !== 1'b0 && n < 200) begin
            n++;
            @(posedge clk);
        end
        if (n >= 200) failures++;
        repeat (4) @(posedge clk);
    endtask : drain
    task automatic peek(input int a, input logic b, input logic [35:0] exp);
        @(posedge clk);
        read_address <= AW'(a);
        read_beat <= b;
        @(posedge clk);
        #1;
        check(read_data, exp);
    endtask : peek
    ////////////////////////////////////////////////////////////////////////////////
    task automatic full_burst;
        dones = 0;
        send(3, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'hF, 4'hF);
        drain();
        peek(3, 1'b0, 36'h1_2345_6789);
        peek(3, 1'b1, 36'hA_BCDE_F012);
        check(36'(dones), 36'h0_0000_0001);
    endtask : full_burst
    task automatic lane_masks;
        logic [3:0] e;
        for (int i = 0; i < 4; i++) begin
            e = 4'h1 << i;
            send(5, 36'h5_5555_5555, 36'h6_6666_6666, 4'hF, 4'hF);
            send(5, 36'hA_AAAA_AAAA, 36'h9_9999_9999, e, ~e);
            drain();
            peek(5, 1'b0, merge(36'h5_5555_5555, 36'hA_AAAA_AAAA, e));
            peek(5, 1'b1, merge(36'h6_6666_6666, 36'h9_9999_9999, ~e));
        end
    endtask : lane_masks
    task automatic fill_queue;
        refused = 0;
        dones = 0;
        for (int i = 0; i < 40; i++) send(i % 16, 36'(i + 100), 36'(i + 200), 4'hF, 4'hF);
        drain();
        check(36'(refused > 0), 36'h0_0000_0001);
        check(36'(dones), 36'h0_0000_0028);
        for (int a = 0; a < 16; a++) begin
            // Last write to address a came from pass a+32 for a<8, else a+16
            peek(a, 1'b0, 36'(a + ((a < 8) ? 132 : 116)));
            peek(a, 1'b1, 36'(a + ((a < 8) ? 232 : 216)));
        end
    endtask : fill_queue
    task automatic end_of_test;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        full_burst();
        lane_masks();
        fill_queue();
        end_of_test();
    end
    // About 250 cycles are needed; this leaves ample margin
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
endmodule : testbench
